// [hdl/cct_pkg.sv]
`default_nettype none
package cct_pkg;
  // ==========================================
  // Widths and register indices (byte address = index * 4)
  localparam int unsigned CW        = 16;
  localparam int unsigned IW        = 8;
  localparam logic [7:0]  IDX_RUN   = 8'h30;
  localparam logic [7:0]  IDX_MODE0 = 8'h38;
  localparam logic [7:0]  IDX_FFCR0 = 8'h39;
  localparam logic [7:0]  IDX_MODE1 = 8'h48;
  localparam logic [7:0]  IDX_FFCR1 = 8'h49;
  localparam logic [7:0]  IDX_DUTY0 = 8'h50;
  localparam logic [7:0]  IDX_PER0  = 8'h51;
  localparam logic [7:0]  IDX_DUTY1 = 8'h52;
  localparam logic [7:0]  IDX_PER1  = 8'h53;
  localparam logic [7:0]  IDX_CAPA0 = 8'h54;
  localparam logic [7:0]  IDX_CAPB0 = 8'h55;
  localparam logic [7:0]  IDX_CAPA1 = 8'h56;
  localparam logic [7:0]  IDX_CAPB1 = 8'h57;
  localparam logic [7:0]  IDX_STAT  = 8'h58;
  // ==========================================
  // Field positions
  localparam int unsigned MODE_CLK_LSB  = 0;
  localparam int unsigned MODE_CLE_BIT  = 2;
  localparam int unsigned MODE_CAPM_LSB = 3;
  localparam int unsigned MODE_CAPIN    = 5;
  localparam int unsigned FF_CMD_LSB    = 0;
  localparam int unsigned FF_EQ_LSB     = 2;
  localparam int unsigned FF_CAP_LSB    = 4;
  localparam int unsigned RUN_PRE_BIT   = 0;
  localparam int unsigned RUN_T_LSB     = 1;
  localparam int unsigned RUN_DB_LSB    = 3;
  // ==========================================
  // Reset values and prescaler taps
  localparam logic [4:0]  MODE_RST      = 5'h00;
  localparam logic [3:0]  FFEN_RST      = 4'h0;
  localparam logic [4:0]  RUN_RST       = 5'h00;
  localparam logic [1:0]  FF_CMD_READ   = 2'h3;
  localparam int unsigned PW            = 6;
  localparam logic [5:0]  TAP1_MASK     = 6'h03;
  localparam logic [5:0]  TAP4_MASK     = 6'h0F;
  localparam logic [5:0]  TAP16_MASK    = 6'h3F;
  // ==========================================
  // Types
  typedef enum logic [1:0] {CAPM_OFF, CAPM_TWO_PIN, CAPM_BOTH_EDGE, CAPM_GATE} cct_capm_e;
  typedef enum logic [1:0] {FFC_INV, FFC_SET, FFC_CLR, FFC_NOP} cct_ffc_e;
  typedef enum logic [1:0] {SRC_EXT, SRC_T1, SRC_T4, SRC_T16} cct_src_e;
  typedef struct packed {
    logic      run;
    logic      db_en;
    logic      clear_en;
    cct_capm_e capm;
    cct_src_e  src;
    logic [3:0] tog_en;
  } cct_cfg_s;
  typedef struct packed {
    logic duty;
    logic period;
    logic ovf;
    logic edge_ev;
  } cct_irq_s;
  typedef struct packed {
    logic [1:0]  we;
    logic [15:0] d;
  } cct_wr_s;
endpackage : cct_pkg
`default_nettype wire

// [hdl/cct_timer.sv]
// What this block does
// - Pulse mode toggles the output on duty and period matches.
// - With buffering on, period match loads buffered duty into active duty.
// - Each unit: counter, two compares, buffer, two captures, comparators, toggle.
// - The two units have own run, buffer and mode bits but share the prescaler and gate input.
// - Compare registers are write-only; reads do not return them.
// - Capture mode 00 disables pin and gate capture (soft capture still works) and is the reset value.
// - Mode 01 captures first on trigger one rise, second on trigger two rise.
// - Mode 10 captures on trigger one rise and fall; edge irq on fall.
// - Mode 11 captures on gating flip-flop rise and fall.
// - Writing 0 to soft capture bit captures counter while prescaler runs.
// - Each comparator flags equality with its own match interrupt.
// - Counter clears on period match only when clear-on-match is set.
// - Toggle flips on the XOR of matches and captures, each gated by own enable.
// - Command field: 00 invert, 01 set, 10 clear, 11 nothing.
// - Command field always reads back as 11.
// - Clock select: 00 external trigger, 01 tap one, 10 tap four, 11 sixteen.
// - Counter wrap past maximum raises overflow interrupt.
`default_nettype none
module cct_unit (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire cct_pkg::cct_cfg_s cfg_i,
  input  wire logic [2:0]       taps_i,
  input  wire logic             trig_first_i,
  input  wire logic             trig_second_i,
  input  wire logic             gate_i,
  input  wire cct_pkg::cct_wr_s duty_wr_i,
  input  wire cct_pkg::cct_wr_s period_wr_i,
  input  wire logic             soft_cap_i,
  input  wire logic             ff_cmd_we_i,
  input  wire cct_pkg::cct_ffc_e ff_cmd_i,
  output logic [15:0]           cap_first_o,
  output logic [15:0]           cap_second_o,
  output logic                  tff_o,
  output cct_pkg::cct_irq_s     irq_o
);
  import cct_pkg::*;
  logic [CW-1:0] cnt;
  logic [CW-1:0] duty;
  logic [CW-1:0] dbuf;
  logic [CW-1:0] period;
  logic          t1_q;
  logic          t2_q;
  logic          g_q;
  // ==========================================
  // Edges and count tick
  wire t1_rise = trig_first_i & ~t1_q;
  wire t1_fall = ~trig_first_i & t1_q;
  wire t2_rise = trig_second_i & ~t2_q;
  wire g_rise  = gate_i & ~g_q;
  wire g_fall  = ~gate_i & g_q;
  wire tap     = (cfg_i.src == SRC_EXT) ? t1_rise :
                 (cfg_i.src == SRC_T1)  ? taps_i[0] :
                 (cfg_i.src == SRC_T4)  ? taps_i[1] : taps_i[2];
  wire tick     = cfg_i.run & tap;
  wire hit_duty = tick & (cnt == duty);
  wire hit_per  = tick & (cnt == period);
  wire clr      = hit_per & cfg_i.clear_en;
  wire wrap     = tick & ~clr & (cnt == {CW{1'b1}});
  wire pin_mode = (cfg_i.capm == CAPM_TWO_PIN) | (cfg_i.capm == CAPM_BOTH_EDGE);
  wire cap1_ev  = soft_cap_i | (pin_mode & t1_rise)
                | ((cfg_i.capm == CAPM_GATE) & g_rise);
  wire cap2_ev  = ((cfg_i.capm == CAPM_TWO_PIN) & t2_rise)
                | ((cfg_i.capm == CAPM_BOTH_EDGE) & t1_fall)
                | ((cfg_i.capm == CAPM_GATE) & g_fall);
  wire edge_ev  = (cfg_i.capm == CAPM_BOTH_EDGE) ? t1_fall : t1_rise;
  wire tog      = ^({cap2_ev, cap1_ev, hit_per, hit_duty} & cfg_i.tog_en);
  // ==========================================
  // Next values
  logic [CW-1:0] next_cnt;
  logic          next_tff;
  always_comb begin
    if (!cfg_i.run || clr) begin
      next_cnt = '0;
    end else if (tick) begin
      next_cnt = cnt + 16'h0001;
    end else begin
      next_cnt = cnt;
    end
  end
  // Software command beats hardware toggles in the same cycle
  always_comb begin
    if (ff_cmd_we_i) begin
      case (ff_cmd_i)
        FFC_INV: next_tff = ~tff_o;
        FFC_SET: next_tff = 1'b1;
        FFC_CLR: next_tff = 1'b0;
        default: next_tff = tff_o ^ tog;
      endcase
    end else begin
      next_tff = tff_o ^ tog;
    end
  end
  // ==========================================
  // State
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      t1_q <= 1'b0;
      t2_q <= 1'b0;
      g_q <= 1'b0;
      tff_o <= 1'b0;
      irq_o <= '0;
    end else begin
      cnt <= next_cnt;
      t1_q <= trig_first_i;
      t2_q <= trig_second_i;
      g_q <= gate_i;
      tff_o <= next_tff;
      irq_o <= '{duty: hit_duty, period: hit_per, ovf: wrap, edge_ev: edge_ev};
    end
  end
  // Compare writes: buffer always, active duty only while unbuffered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty <= '0;
      dbuf <= '0;
      period <= '0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (duty_wr_i.we[b]) dbuf[b*8 +: 8] <= duty_wr_i.d[b*8 +: 8];
        if (duty_wr_i.we[b] && !cfg_i.db_en) duty[b*8 +: 8] <= duty_wr_i.d[b*8 +: 8];
        if (period_wr_i.we[b]) period[b*8 +: 8] <= period_wr_i.d[b*8 +: 8];
      end
      if (hit_per && cfg_i.db_en) duty <= dbuf;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_first_o <= '0;
      cap_second_o <= '0;
    end else begin
      if (cap1_ev) cap_first_o <= cnt;
      if (cap2_ev) cap_second_o <= cnt;
    end
  end
  // ==========================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_per_tick;
    tick && cnt == period;
  endsequence
  sequence s_lone_per;
    s_per_tick ##0 (cfg_i.tog_en == 4'h3 && cnt != duty && !ff_cmd_we_i && !cap1_ev && !cap2_ev);
  endsequence
  AST_HOLD: assert property (!cfg_i.run |=> cnt == 16'h0000)
    else $error("counter not held at zero while stopped");
  AST_INC: assert property (tick && !clr && !wrap
    |=> cnt == $past(cnt) + 16'h0001)
    else $error("counter did not advance by one");
  AST_CLR: assert property (s_per_tick ##0 cfg_i.clear_en |=> cnt == 16'h0000)
    else $error("period match did not clear counter");
  AST_DUTY: assert property (tick && cnt == duty |=> irq_o.duty)
    else $error("duty match irq missing");
  AST_DBUF: assert property (s_per_tick ##0 cfg_i.db_en |=> duty == $past(dbuf))
    else $error("buffered duty not transferred");
  AST_OVF: assert property (wrap |=> irq_o.ovf && cnt == 16'h0000)
    else $error("overflow not flagged");
  AST_CAP1: assert property (cfg_i.capm == CAPM_TWO_PIN && t1_rise
    |=> cap_first_o == $past(cnt))
    else $error("first capture missed");
  AST_CAP2: assert property (cfg_i.capm == CAPM_BOTH_EDGE && t1_fall
    |=> cap_second_o == $past(cnt) && irq_o.edge_ev)
    else $error("falling capture missed");
  AST_SET: assert property (ff_cmd_we_i && ff_cmd_i == FFC_SET |=> tff_o)
    else $error("set command ignored");
  AST_PPG: assert property (s_lone_per |=> tff_o != $past(tff_o))
    else $error("output did not toggle on period match");
endmodule : cct_unit

module cct_timer #(
  parameter int unsigned AW = 10
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic [AW-1:0] wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic          wb_we_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic [1:0]    trigger_input_first_i,
  input  wire logic [1:0]    trigger_input_second_i,
  input  wire logic          gating_ff_from_byte_timers_i,
  output logic [1:0]         timer_output_pin_o,
  output logic [1:0]         duty_match_irq_o,
  output logic [1:0]         period_match_irq_o,
  output logic [1:0]         overflow_irq_o,
  output logic [1:0]         trigger_edge_irq_o
);
  import cct_pkg::*;
  logic [4:0]    run_reg;
  logic [4:0]    mode [2];
  logic [3:0]    ffen [2];
  logic [PW-1:0] pre;
  logic [15:0]   cap_a [2];
  logic [15:0]   cap_b [2];
  logic [31:0]   rd [2];
  // ==========================================
  // Bus decode
  wire [IW-1:0] idx  = wb_adr_i[IW+1:2];
  wire          wr   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  wire          lo   = wr & wb_sel_i[0];
  wire          prun = run_reg[RUN_PRE_BIT];
  wire [2:0]    taps = {3{prun}} & {(pre & TAP16_MASK) == TAP16_MASK,
                                    (pre & TAP4_MASK) == TAP4_MASK,
                                    (pre & TAP1_MASK) == TAP1_MASK};
  wire [31:0] rd_run  = (idx == IDX_RUN) ? {27'h0, run_reg} : 32'h0;
  wire [31:0] rd_stat = (idx == IDX_STAT) ? {30'h0, timer_output_pin_o} : 32'h0;
  // ==========================================
  // Units
  for (genvar u = 0; u < 2; u++) begin : g_unit
    localparam logic [7:0] MI = u ? IDX_MODE1 : IDX_MODE0;
    localparam logic [7:0] FI = u ? IDX_FFCR1 : IDX_FFCR0;
    localparam logic [7:0] DI = u ? IDX_DUTY1 : IDX_DUTY0;
    localparam logic [7:0] PI = u ? IDX_PER1 : IDX_PER0;
    localparam logic [7:0] AI = u ? IDX_CAPA1 : IDX_CAPA0;
    localparam logic [7:0] BI = u ? IDX_CAPB1 : IDX_CAPB0;
    cct_cfg_s cfg;
    cct_irq_s irq;
    cct_wr_s  dwr;
    cct_wr_s  pwr;
    logic     tff;
    wire mode_we  = lo & (idx == MI);
    wire ff_we    = lo & (idx == FI);
    wire soft_cap = mode_we & ~wb_dat_i[MODE_CAPIN] & prun;
    assign cfg = '{run: run_reg[RUN_T_LSB+u], db_en: run_reg[RUN_DB_LSB+u],
                   clear_en: mode[u][MODE_CLE_BIT],
                   capm: cct_capm_e'(mode[u][MODE_CAPM_LSB +: 2]),
                   src: cct_src_e'(mode[u][MODE_CLK_LSB +: 2]), tog_en: ffen[u]};
    assign dwr = '{we: {2{wr & (idx == DI)}} & wb_sel_i[1:0], d: wb_dat_i[15:0]};
    assign pwr = '{we: {2{wr & (idx == PI)}} & wb_sel_i[1:0], d: wb_dat_i[15:0]};
    // Compare indices fall through to zero on reads
    assign rd[u] = (idx == MI) ? {26'h0, 1'b1, mode[u]} :
                   (idx == FI) ? {26'h0, ffen[u], FF_CMD_READ} :
                   (idx == AI) ? {16'h0, cap_a[u]} :
                   (idx == BI) ? {16'h0, cap_b[u]} : 32'h0;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mode[u] <= MODE_RST;
        ffen[u] <= FFEN_RST;
      end else begin
        if (mode_we) mode[u] <= wb_dat_i[4:0];
        if (ff_we) ffen[u] <= wb_dat_i[FF_EQ_LSB +: 4];
      end
    end
    cct_unit u_unit (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .cfg_i         (cfg),
      .taps_i        (taps),
      .trig_first_i  (trigger_input_first_i[u]),
      .trig_second_i (trigger_input_second_i[u]),
      .gate_i        (gating_ff_from_byte_timers_i),
      .duty_wr_i     (dwr),
      .period_wr_i   (pwr),
      .soft_cap_i    (soft_cap),
      .ff_cmd_we_i   (ff_we),
      .ff_cmd_i      (cct_ffc_e'(wb_dat_i[FF_CMD_LSB +: 2])),
      .cap_first_o   (cap_a[u]),
      .cap_second_o  (cap_b[u]),
      .tff_o         (tff),
      .irq_o         (irq)
    );
    assign timer_output_pin_o[u] = tff;
    assign duty_match_irq_o[u]   = irq.duty;
    assign period_match_irq_o[u] = irq.period;
    assign overflow_irq_o[u]     = irq.ovf;
    assign trigger_edge_irq_o[u] = irq.edge_ev;
  end
  // ==========================================
  // Run register, prescaler and bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg <= RUN_RST;
      pre <= '0;
    end else begin
      if (lo && idx == IDX_RUN) run_reg <= wb_dat_i[4:0];
      pre <= prun ? pre + 6'h01 : 6'h00;
    end
  end
  // Single-wait answer; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rd[0] | rd[1] | rd_run | rd_stat;
    end
  end
endmodule : cct_timer
`default_nettype wire

// [testbench/tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cct_pkg::*;
  logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, gate;
  logic [9:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i;
  logic [1:0]  trig1, trig2, pin, duty_irq, per_irq, ovf_irq, edge_irq;
  logic [31:0] exp_q[$];
  int          errors, n_compared, n_duty, n_per, n_edge, e0, seed, n_ticks, n_duty1, n_per1;
  int          n_ovf;
  // ==========================================
  // Clock, reset, design
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  cct_timer i_cct_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .trigger_input_first_i(trig1), .trigger_input_second_i(trig2),
    .gating_ff_from_byte_timers_i(gate), .timer_output_pin_o(pin),
    .duty_match_irq_o(duty_irq), .period_match_irq_o(per_irq),
    .overflow_irq_o(ovf_irq), .trigger_edge_irq_o(edge_irq));
  // ==========================================
  // Shared tasks
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare
  task automatic close_out;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  // Request held until ack is sampled, released at that same edge
  task automatic bus(input logic we, input logic [7:0] idx, input logic [31:0] d,
                     input logic [3:0] sel);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= d;
    wb_sel_i <= sel;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    bus(1'b1, idx, {16'h0, d}, (idx >= IDX_DUTY0 && idx <= IDX_PER1) ? 4'h3 : 4'h1);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, idx, 32'h0, 4'hF);
  endtask : rd
  task automatic tick(input int u = 0);
    @(posedge clk_i);
    trig1[u] <= 1'b1;
    repeat (3) @(posedge clk_i);
    trig1[u] <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : tick
  task automatic settle;
    repeat (4) @(posedge clk_i);
  endtask : settle
  // Status; unit one defaults to the level left by the command walk
  task automatic st(input logic b0, input logic b1 = 1'b1);
    rd(IDX_STAT, {30'h0, b1, b0});
    compare({30'h0, pin}, {30'h0, b1, b0});
  endtask : st
  // ==========================================
  // Watcher: read data against oldest note, interrupt pulse counts
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
      if (exp_q.size() == 0) begin
        compare(wb_dat_o, 32'hFFFF_FFFF);
      end else begin
        compare(wb_dat_o, exp_q.pop_front());
      end
    end
    if (duty_irq[0] === 1'b1) n_duty++;
    if (per_irq[0] === 1'b1) n_per++;
    if (edge_irq[0] === 1'b1) n_edge++;
    if (duty_irq[1] === 1'b1) n_duty1++;
    if (per_irq[1] === 1'b1) n_per1++;
    if (ovf_irq[0] === 1'b1 || ovf_irq[1] === 1'b1) n_ovf++;
  end
  initial begin
    #(25ns * 20000);
    errors++;
    close_out();
  end
  // ==========================================
  // Main sequence
  initial begin
    logic [1:0] cmds[4];
    logic       outs[4];
    cmds = '{2'h1, 2'h2, 2'h0, 2'h3};
    outs = '{1'b1, 1'b0, 1'b1, 1'b1};
    seed = 8822;
    {wb_we_i, wb_cyc_i, wb_stb_i, gate, trig1, trig2} = '0;
    wb_adr_i = '0;
    wb_dat_i = '0;
    wb_sel_i = '0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_RUN, 32'h0);
    rd(IDX_MODE0, 32'h20);
    rd(IDX_FFCR0, 32'h03);
    rd(IDX_STAT, 32'h0);
    rd(8'h7F, 32'h0);
    wr(IDX_DUTY0, 16'h1234);
    rd(IDX_DUTY0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_FFCR1, {14'h0, cmds[i]});
      rd(IDX_STAT, {30'h0, outs[i], 1'b0});
      rd(IDX_FFCR1, 32'h03);
    end
    // External event counting, software capture
    n_ticks = 3 + ($unsigned($random(seed)) % 5);
    wr(IDX_RUN, 16'h03);
    wr(IDX_MODE0, 16'h20);
    for (int i = 0; i < n_ticks; i++) tick();
    rd(IDX_CAPA0, 32'h0);
    wr(IDX_MODE0, 16'h00);
    rd(IDX_CAPA0, n_ticks);
    tick();
    wr(IDX_RUN, 16'h02);
    wr(IDX_MODE0, 16'h00);
    rd(IDX_CAPA0, n_ticks);
    wr(IDX_RUN, 16'h01);
    wr(IDX_MODE0, 16'h00);
    rd(IDX_CAPA0, 32'h0);
    // Pulse mode with clear on period match
    wr(IDX_PER0, 16'h0004);
    wr(IDX_DUTY0, 16'h0002);
    wr(IDX_FFCR0, 16'h0E);
    wr(IDX_MODE0, 16'h24);
    n_duty = 0;
    n_per = 0;
    wr(IDX_RUN, 16'h03);
    for (int i = 0; i < 3; i++) tick();
    st(1'b1);
    for (int i = 0; i < 4; i++) tick();
    st(1'b0);
    wr(IDX_MODE0, 16'h04);
    rd(IDX_CAPA0, 32'h2);
    compare(n_duty, 1);
    compare(n_per, 1);
    // Capture sources with capture toggles on
    wr(IDX_FFCR0, 16'h33);
    tick();
    wr(IDX_MODE0, 16'h3C);
    gate <= 1'b1;
    settle();
    rd(IDX_CAPA0, 32'h3);
    st(1'b1);
    gate <= 1'b0;
    settle();
    rd(IDX_CAPB0, 32'h3);
    st(1'b0);
    wr(IDX_MODE0, 16'h24);
    tick();
    wr(IDX_MODE0, 16'h2C);
    trig2[0] <= 1'b1;
    settle();
    rd(IDX_CAPB0, 32'h4);
    st(1'b1);
    trig2[0] <= 1'b0;
    wr(IDX_MODE0, 16'h34);
    e0 = n_edge;
    trig1[0] <= 1'b1;
    settle();
    compare(n_edge - e0, 0);
    trig1[0] <= 1'b0;
    settle();
    compare(n_edge - e0, 1);
    rd(IDX_CAPB0, 32'h0);
    st(1'b1);
    rd(IDX_CAPA1, 32'h0);
    rd(IDX_CAPB1, 32'h0);
    // ==========================================
    // Second unit: buffered duty, trigger-one capture, prescaler tap
    wr(IDX_PER1, 16'h0004);
    wr(IDX_DUTY1, 16'h0001);
    wr(IDX_FFCR1, 16'h0E);
    wr(IDX_MODE1, 16'h24);
    wr(IDX_RUN, 16'h15);
    wr(IDX_DUTY1, 16'h0003);
    for (int i = 0; i < 2; i++) tick(1);
    st(1'b1, 1'b1);
    for (int i = 0; i < 6; i++) tick(1);
    st(1'b1, 1'b0);
    wr(IDX_MODE1, 16'h2C);
    tick(1);
    st(1'b1, 1'b1);
    rd(IDX_CAPA1, 32'h3);
    compare(n_duty1, 2);
    compare(n_per1, 1);
    // Tap one ticks every fourth clock once the prescaler restarts from zero
    wr(IDX_RUN, 16'h00);
    wr(IDX_MODE1, 16'h21);
    wr(IDX_RUN, 16'h05);
    repeat (40) @(posedge clk_i);
    wr(IDX_MODE1, 16'h01);
    rd(IDX_CAPA1, 32'hA);
    compare(n_ovf, 0);
    settle();
    close_out();
  end
endmodule : tb
`default_nettype wire
